// File: shared/spim_pkg.sv
// Purpose: Constants and carrier types shared by the serial master.
// Assumes: One system clock; configuration bits are driven by logic on that clock.
// Notes:   The transmit word keeps the layout of the transmit data register.
package spim_pkg;

    localparam int          SPIM_DATA_W     = 16;
    localparam int          SPIM_DATA_LSB   = 0;
    localparam int          SPIM_PCS_LSB    = 16;
    localparam int          SPIM_PCS_W      = 2;
    localparam int          SPIM_LAST_BIT   = 24;
    localparam int          SPIM_WORD_W     = 32;
    localparam int          SPIM_CS_NUM     = 4;
    localparam int          SPIM_BUF_DEPTH  = 2;
    localparam logic [4:0]  SPIM_BASE_BITS  = 5'h08;
    localparam logic [3:0]  SPIM_MAX_CODE   = 4'h8;
    localparam logic [7:0]  SPIM_DIV_ONE    = 8'h01;
    localparam logic [5:0]  SPIM_EXTRA_EDGE = 6'h02;
    localparam logic [3:0]  SPIM_CS_IDLE    = 4'hf;

    typedef enum logic [1:0]
    {
        SPIM_ST_IDLE  = 2'b00,
        SPIM_ST_SHIFT = 2'b01,
        SPIM_ST_DONE  = 2'b10
    } spim_state_e;

    typedef struct packed
    {
        logic                  master_select_bit;
        logic                  fixed_mode;
        logic                  cs_hold_after_transfer;
        logic                  dma_mode;
        logic [SPIM_PCS_W-1:0] fixed_pcs;
        logic [7:0]            serial_clock_divider;
        logic [3:0][3:0]       bits_code;
    } spim_cfg_s;

endpackage

// File: verilog/spim_master.sv
// Purpose: Serial master that keeps the known anomalies of the original block.
// Assumes: Configuration and transmit words come from logic on sys_clk_in.
// Notes:   Anomalies are kept on purpose; software rules are listed but not enforced.
// Summary of operation
// - Held select, divider one: resend after idle.
// - DMA last bit frees select on empty.
// - Early configuration makes clock toggle before the first transfer.
// - DMA size follows select zero width in fixed.
// - Divider one, odd width: one extra pulse.
// - Divider one, even width: exact pulse count.
`timescale 1ns/1ps

module spim_master
    import spim_pkg::*;
#(
    parameter int BUF_DEPTH = SPIM_BUF_DEPTH
)
(
    input  wire logic                   sys_clk_in,
    input  wire logic                   arst_n_in,
    input  wire logic                   ce_in,
    input  wire spim_cfg_s              cfg_in,
    input  wire logic                   cs_cfg_wr_in,
    input  wire logic                   tx_valid_in,
    input  wire logic [SPIM_WORD_W-1:0] tx_word_in,
    input  wire logic                   miso_in,
    output logic                        tx_ready_out,
    output logic                        transmit_empty_flag_out,
    output logic                        dma_size_out,
    output logic                        sclk_out,
    output logic                        mosi_out,
    output logic [SPIM_CS_NUM-1:0]      cs_n_out,
    output logic [SPIM_DATA_W-1:0]      rx_data_out,
    output logic                        rx_valid_out
);

    typedef struct packed
    {
        spim_state_e                     st;
        logic [1:0][SPIM_WORD_W-1:0]     fifo;
        logic                            wptr;
        logic                            rptr;
        logic [1:0]                      count;
        logic                            tx_ready;
        logic                            tx_empty;
        logic                            lastx_latch;
        logic                            cur_last;
        logic [SPIM_PCS_W-1:0]           cur_pcs;
        logic [SPIM_PCS_W-1:0]           prev_pcs;
        logic                            was_idle;
        logic [SPIM_DATA_W-1:0]          shift;
        logic [SPIM_DATA_W-1:0]          rxsh;
        logic [SPIM_DATA_W-1:0]          rx_data;
        logic                            rx_valid;
        logic [5:0]                      edges;
        logic [7:0]                      divcnt;
        logic                            sclk;
        logic                            mosi;
        logic [SPIM_CS_NUM-1:0]          cs_n;
        logic                            dma_size;
        logic                            early;
        logic                            first_done;
        logic                            master_prev;
        logic                            miso_s1;
        logic                            miso_s2;
    } spim_reg_s;

    localparam spim_reg_s RST_VAL = '{st: SPIM_ST_IDLE, cs_n: SPIM_CS_IDLE, tx_ready: 1'b1,
                                      tx_empty: 1'b1, default: '0};

    initial
    begin
        if (BUF_DEPTH != SPIM_BUF_DEPTH)
        begin
            $error("spim_master serves a buffer depth of two only");
        end
    end

    function automatic logic [4:0] spim_width(input logic [3:0] code);
        spim_width = (code > SPIM_MAX_CODE) ? SPIM_BASE_BITS : SPIM_BASE_BITS + {1'b0, code};
    endfunction

    spim_reg_s               r_q;
    spim_reg_s               r_d;
    logic                    push;
    logic                    pop;
    logic                    load;
    logic                    resend;
    logic                    div_one;
    logic [7:0]              div_eff;
    logic [SPIM_WORD_W-1:0]  head;
    logic [SPIM_PCS_W-1:0]   pcs;
    logic [4:0]              width;
    logic                    odd_extra;
    logic                    master_rise;
    logic                    glitch;
    logic                    last_release;
    logic                    cs0_wide;

    always_comb
    begin
        r_d          = r_q;
        r_d.rx_valid = 1'b0;
        r_d.miso_s1  = miso_in;
        r_d.miso_s2  = r_q.miso_s1;
        r_d.master_prev = cfg_in.master_select_bit;
        div_eff      = (cfg_in.serial_clock_divider == 8'h00) ? SPIM_DIV_ONE
                                                              : cfg_in.serial_clock_divider;
        div_one      = (div_eff == SPIM_DIV_ONE);
        head         = r_q.fifo[r_q.rptr];
        pcs          = cfg_in.fixed_mode ? cfg_in.fixed_pcs
                                         : head[SPIM_PCS_LSB +: SPIM_PCS_W];
        width        = spim_width(cfg_in.bits_code[pcs]);
        odd_extra    = div_one && width[0];
        push         = tx_valid_in && r_q.tx_ready;
        load         = (r_q.st == SPIM_ST_IDLE) && cfg_in.master_select_bit && (r_q.count != 2'h0);
        // The original block loses its ready edge here, so the word is kept and shifted again.
        resend       = load && cfg_in.cs_hold_after_transfer && div_one && r_q.was_idle &&
                       (pcs == r_q.prev_pcs) && !r_q.cs_n[pcs];
        pop          = load && !resend;
        master_rise  = cfg_in.master_select_bit && !r_q.master_prev;
        glitch       = (r_q.st == SPIM_ST_IDLE) && master_rise && r_q.early && !r_q.first_done;
        if (cs_cfg_wr_in && !cfg_in.master_select_bit)
        begin
            r_d.early = 1'b1;
        end
        case (r_q.st)
            SPIM_ST_IDLE:
            begin
                r_d.sclk = 1'b0;
                if (glitch)
                begin
                    r_d.sclk  = 1'b1;
                    r_d.early = 1'b0;
                end
                if (load)
                begin
                    r_d.cur_pcs    = pcs;
                    r_d.cur_last   = head[SPIM_LAST_BIT];
                    r_d.cs_n       = ~(SPIM_CS_NUM'(1) << pcs);
                    r_d.shift      = head[SPIM_DATA_LSB +: SPIM_DATA_W] << (5'd16 - width);
                    r_d.mosi       = r_d.shift[SPIM_DATA_W-1];
                    r_d.edges      = {width, 1'b0} + (odd_extra ? SPIM_EXTRA_EDGE : 6'h00);
                    r_d.divcnt     = div_eff;
                    r_d.first_done = 1'b1;
                    r_d.was_idle   = 1'b0;
                    r_d.early      = 1'b0;
                    r_d.st         = SPIM_ST_SHIFT;
                end
                else if (r_q.count == 2'h0 && r_q.cs_n != SPIM_CS_IDLE)
                begin
                    r_d.was_idle = 1'b1;
                end
            end
            SPIM_ST_SHIFT:
            begin
                if (r_q.divcnt <= 8'h01)
                begin
                    r_d.divcnt = div_eff;
                    r_d.sclk   = ~r_q.sclk;
                    r_d.edges  = r_q.edges - 6'h01;
                    if (!r_q.sclk)
                    begin
                        r_d.rxsh = {r_q.rxsh[SPIM_DATA_W-2:0], r_q.miso_s2};
                    end
                    else
                    begin
                        r_d.shift = {r_q.shift[SPIM_DATA_W-2:0], 1'b0};
                        r_d.mosi  = r_q.shift[SPIM_DATA_W-2];
                    end
                    if (r_q.edges == 6'h01)
                    begin
                        r_d.st = SPIM_ST_DONE;
                    end
                end
                else
                begin
                    r_d.divcnt = r_q.divcnt - 8'h01;
                end
            end
            SPIM_ST_DONE:
            begin
                r_d.rx_data  = r_q.rxsh;
                r_d.rx_valid = 1'b1;
                r_d.prev_pcs = r_q.cur_pcs;
                if (!cfg_in.cs_hold_after_transfer || r_q.cur_last)
                begin
                    r_d.cs_n = SPIM_CS_IDLE;
                end
                r_d.st = SPIM_ST_IDLE;
            end
            default:
            begin
                r_d.st = SPIM_ST_IDLE;
            end
        endcase
        if (push)
        begin
            r_d.fifo[r_q.wptr] = tx_word_in;
            r_d.wptr           = ~r_q.wptr;
            r_d.lastx_latch    = tx_word_in[SPIM_LAST_BIT];
        end
        if (pop)
        begin
            r_d.rptr = ~r_q.rptr;
        end
        r_d.count    = r_q.count + {1'b0, push} - {1'b0, pop};
        r_d.tx_ready = (r_d.count < 2'h2);
        r_d.tx_empty = (r_d.count == 2'h0) && (r_d.st == SPIM_ST_IDLE);
        // The select follows the last word written, not the word that was shifted.
        last_release = r_d.tx_empty && !r_q.tx_empty && cfg_in.fixed_mode &&
                       cfg_in.cs_hold_after_transfer && cfg_in.dma_mode && r_q.lastx_latch;
        if (last_release)
        begin
            r_d.cs_n = SPIM_CS_IDLE;
        end
        cs0_wide     = spim_width(cfg_in.bits_code[0]) > SPIM_BASE_BITS;
        r_d.dma_size = cfg_in.fixed_mode ? cs0_wide
                                         : (spim_width(cfg_in.bits_code[pcs]) > SPIM_BASE_BITS);
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            r_q <= RST_VAL;
        end
        else if (ce_in)
        begin
            r_q <= r_d;
        end
    end

    assign tx_ready_out            = r_q.tx_ready;
    assign transmit_empty_flag_out = r_q.tx_empty;
    assign dma_size_out            = r_q.dma_size;
    assign sclk_out                = r_q.sclk;
    assign mosi_out                = r_q.mosi;
    assign cs_n_out                = r_q.cs_n;
    assign rx_data_out             = r_q.rx_data;
    assign rx_valid_out            = r_q.rx_valid;

    default clocking spim_cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    chk_resend_keeps_word: assert property (ce_in && resend |=> r_q.rptr == $past(r_q.rptr))
        else $error("resent word was popped");
    chk_last_frees_cs: assert property (ce_in && last_release |=> cs_n_out == SPIM_CS_IDLE)
        else $error("select not freed on empty");
    chk_early_clock_toggle: assert property (ce_in && glitch |=> sclk_out ##1 (!sclk_out || !ce_in))
        else $error("early clock pulse missing");
    chk_dma_size_cs0: assert property (ce_in && cfg_in.fixed_mode |=> dma_size_out == $past(cs0_wide))
        else $error("size does not follow select zero");
    chk_odd_extra_pulse: assert property (ce_in && load && odd_extra
                                          |=> r_q.edges == $past({width, 1'b0}) + 6'h02)
        else $error("odd width lacks extra pulse");
    chk_even_exact_pulse: assert property (ce_in && load && div_one && !width[0]
                                           |=> r_q.edges == $past({width, 1'b0}))
        else $error("even width pulse count wrong");
    chk_ready_tracks_fill: assert property (ce_in && push && !pop && r_q.count == 2'h1
                                            |=> !tx_ready_out && !transmit_empty_flag_out)
        else $error("ready high while buffer full");

endmodule

// File: test/spim_slave_model.sv
// Purpose: Serial slave on the far side of the master, mode 0.
// Assumes: Master outputs are registered on sys_clk_in.
// Notes:   Counts rising serial edges of a word and collects the bits seen on them.
`timescale 1ns/1ps

module spim_slave_model
(
    input  wire logic        sys_clk_in,
    input  wire logic        sclk_in,
    input  wire logic        mosi_in,
    input  wire logic [3:0]  cs_n_in,
    input  wire logic        rx_valid_in,
    output logic             miso_out,
    output int               edge_cnt_out,
    output logic [16:0]      bits_out
);
    logic sclk_q;

    initial
    begin
        sclk_q = 1'b0;
        edge_cnt_out = 0;
        bits_out = '0;
    end

    // The data line has a pull-up and the slave answers with all ones, so the received word is
    // known even though the master samples it through a two-flop synchroniser.
    assign miso_out = 1'b1;

    // Only rising edges inside a frame count, so a stray pulse before the first word is ignored.
    always @(posedge sys_clk_in)
    begin
        sclk_q <= sclk_in;
        if (rx_valid_in)
        begin
            edge_cnt_out <= 0;
            bits_out <= '0;
        end
        else if (!sclk_q && sclk_in && cs_n_in != 4'hf)
        begin
            edge_cnt_out <= edge_cnt_out + 1;
            bits_out <= {bits_out[15:0], mosi_in};
        end
    end
endmodule

// File: test/spim_master_tb.sv
// Purpose: Self-checking bench for the serial master.
// Assumes: Clock enable drops once in mid-word; one slave model watches every select.
// Notes:   Each sent word notes its expected edge count and bits in a queue.
`timescale 1ns/1ps

module spim_master_tb import spim_pkg::*;;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   ce, cs_wr, tx_valid, miso, tx_ready, tx_empty;
    logic                   dma_size, sclk, mosi, rx_valid;
    logic [SPIM_WORD_W-1:0] tx_word, w;
    logic [3:0]             cs_n;
    logic [16:0]            cap_bits;
    logic [SPIM_DATA_W-1:0] rx_data;
    int                     cap_cnt, hi, n;
    spim_cfg_s              cfg;
    logic [31:0]            seed = 32'hea70;
    logic [16:0]            exp_bits[$];
    int                     exp_cnt[$];
    int                     err_total = 0;
    int                     tests_run = 0;

    initial
    begin
        forever #25 clk = ~clk;
    end

    spim_master u_dut (.sys_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .cfg_in(cfg),
        .cs_cfg_wr_in(cs_wr), .tx_valid_in(tx_valid), .tx_word_in(tx_word), .miso_in(miso),
        .tx_ready_out(tx_ready), .transmit_empty_flag_out(tx_empty), .dma_size_out(dma_size),
        .sclk_out(sclk), .mosi_out(mosi), .cs_n_out(cs_n), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid));

    spim_slave_model u_slave (.sys_clk_in(clk), .sclk_in(sclk), .mosi_in(mosi),
        .cs_n_in(cs_n), .rx_valid_in(rx_valid), .miso_out(miso),
        .edge_cnt_out(cap_cnt), .bits_out(cap_bits));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic note(input logic [31:0] v, input int wd, input int odd);
        exp_cnt.push_back(wd + odd);
        exp_bits.push_back(17'((v & ((32'h1 << wd) - 1)) << odd));
    endtask

    // The word is held until an edge that sees ready high, so nothing is lost on a stall.
    task automatic send(input logic [31:0] v);
        @(posedge clk);
        #2;
        tx_valid = 1'b1;
        tx_word = v;
        do @(negedge clk); while (tx_ready !== 1'b1);
        @(posedge clk);
        #2;
        tx_valid = 1'b0;
    endtask

    task automatic drain();
        for (int i = 0; i < 3000 && exp_cnt.size() != 0; i++)
            @(posedge clk);
        if (exp_cnt.size() != 0)
            check(1'b0, "word missing");
        repeat (4) @(posedge clk);
        #2;
    endtask

    always @(negedge clk)
    begin
        if (rx_valid === 1'b1)
        begin
            if (exp_cnt.size() == 0)
                check(1'b0, "unexpected word");
            else
            begin
                n = exp_cnt.pop_front();
                check(cap_cnt == n, "edge count");
                check(cap_bits === exp_bits.pop_front(), "serial data");
                check(&(rx_data | ~16'((32'h1 << n) - 1)), "received data");
            end
        end
    end

    initial
    begin
        #2000000;
        check(1'b0, "timeout");
        end_sim();
    end

    initial
    begin
        ce = 1'b1;
        cs_wr = 1'b0;
        tx_valid = 1'b0;
        tx_word = '0;
        cfg = '0;
        repeat (10) @(posedge clk);
        #2;
        rst_n = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            #2;
            cs_wr = 1'b1;
            @(posedge clk);
            #2;
            cs_wr = 1'b0;
            cfg.master_select_bit = 1'b1;
            hi = 0;
            repeat (8)
            begin
                @(negedge clk);
                hi += int'(sclk === 1'b1 && cs_n === 4'hf);
            end
            check(hi == 1 - k, "early serial clock");
        end
        @(posedge clk);
        #2;
        cfg.serial_clock_divider = SPIM_DIV_ONE;
        for (int c = 0; c < 9; c++)
        begin
            cfg.bits_code = {4{4'(c)}};
            w = xs();
            note(w, 8 + c, c % 2);
            send(w);
            drain();
        end
        // A zero divider runs as one, and a width code above eight acts as zero.
        cfg.serial_clock_divider = 8'h00;
        cfg.bits_code = {4{4'h9}};
        w = xs();
        note(w, 8, 0);
        send(w);
        drain();
        cfg.serial_clock_divider = 8'h03;
        cfg.bits_code = {4{4'h1}};
        w = xs();
        note(w, 9, 0);
        send(w);
        @(posedge clk);
        #2;
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        ce = 1'b1;
        drain();
        cfg.fixed_mode = 1'b1;
        cfg.dma_mode = 1'b1;
        cfg.fixed_pcs = 2'h1;
        cfg.bits_code = {4'h0, 4'h0, 4'h0, 4'h2};
        repeat (2) @(posedge clk);
        #2;
        check(dma_size === 1'b1, "size from select zero");
        cfg.bits_code[0] = 4'h0;
        repeat (2) @(posedge clk);
        #2;
        check(dma_size === 1'b0, "byte size");
        cfg.serial_clock_divider = 8'h02;
        w = xs();
        w[SPIM_LAST_BIT] = 1'b0;
        note(w, 8, 0);
        send(w);
        do @(negedge clk); while (tx_empty !== 1'b1);
        check(cs_n === 4'hf, "select left to general I/O");
        cfg.cs_hold_after_transfer = 1'b1;
        cfg.serial_clock_divider = 8'h02;
        for (int k = 0; k < 2; k++)
        begin
            w = xs();
            w[SPIM_LAST_BIT] = k[0];
            note(w, 8, 0);
            send(w);
            do @(negedge clk); while (tx_empty !== 1'b1);
            check(cs_n === ((k == 1) ? 4'hf : 4'hd), "select at empty");
        end
        drain();
        // Hold with divider one is kept for last because it repeats a word after a gap.
        cfg = '0;
        cfg.master_select_bit = 1'b1;
        cfg.cs_hold_after_transfer = 1'b1;
        cfg.serial_clock_divider = SPIM_DIV_ONE;
        for (int k = 0; k < 3; k++)
        begin
            w = xs();
            w[17:16] = 2'h2;
            w[SPIM_LAST_BIT] = (k == 2);
            note(w, 8, 0);
            if (k == 1)
                note(w, 8, 0);
            send(w);
            if (k == 0)
                drain();
        end
        drain();
        check(cs_n === 4'hf, "select released");
        end_sim();
    end
endmodule
